//--- core/wave_steer_ctrl.sv
// waveform source select, auto-shutdown and output steering with axi4-lite
// Summary of operation
// R1: logic cell 2 output trips shutdown only while its enable bit 4 is set
// R2: comparator 2 output trips shutdown only while enable bit 3 is set
// R3: comparator 1 output trips shutdown only while enable bit 2 is set
// R4: timer postscaled output trips shutdown only while enable bit 1 is set
// R5: routed input pin trips shutdown only while enable bit 0 is set
// R6: steered output carries the data waveform, xor its polarity bit
// R7: unsteered output carries its override level bit
// R8: steering register: overrides D..A in bits 7..4, enables D..A in 3..0
// R9: steering and overrides act only in modes 000 and 001
// R10: in mode 001 steering enables update only at a waveform rising edge
// R11: clock select 1 counts on fast oscillator ticks, 0 on system clock
// R12: four-bit select picks the waveform source from fourteen inputs
// R13: select codes 1110 and 1111 connect no source
// R14: mode 001 is synchronous steering, 000 plain steering
// R15: polarity bit set inverts its output
// R16: with auto-restart the shutdown flag clears once all enabled sources are low
// R17: enabled high source sets shutdown flag and forces shutdown levels
// R18: unimplemented bits ignore writes and read zero
`timescale 1ns/1ps
`default_nettype none
module wave_steer_ctrl (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        wave_pin_i,
  input  wire logic        ccp1_i,
  input  wire logic        ccp2_i,
  input  wire logic        pwm3_i,
  input  wire logic        pwm4_i,
  input  wire logic        pwm5_i,
  input  wire logic        pwm6_i,
  input  wire logic        nco_i,
  input  wire logic        comparator1_i,
  input  wire logic        comparator2_i,
  input  wire logic        logic_cell1_i,
  input  wire logic        logic_cell2_output_i,
  input  wire logic        logic_cell3_i,
  input  wire logic        logic_cell4_i,
  input  wire logic        trip_pin_i,
  input  wire logic        eight_bit_timer_post_i,
  input  wire logic        fast_internal_oscillator_i,
  output logic [3:0]       out_o,
  output logic [3:0]       out_oe_n_o,
  output logic             irq_o
);

  function automatic logic [3:0] reg_index(input logic [5:0] addr);
    reg_index = (addr[5:2] < 4'(wave_steer_pkg::NREG)) ? addr[5:2] : 4'hf;
  endfunction

  // input synchronisers: 14 sources, trip pin, timer post
  logic [15:0] async_in;
  logic [15:0] sync1_reg;
  logic [15:0] sync2_reg;
  logic [1:0]  osc_sync_reg;
  logic        osc_prev_reg;
  assign async_in = {eight_bit_timer_post_i, trip_pin_i, logic_cell4_i,
                     logic_cell3_i, logic_cell2_output_i, logic_cell1_i,
                     comparator2_i, comparator1_i, nco_i, pwm6_i, pwm5_i,
                     pwm4_i, pwm3_i, ccp2_i, ccp1_i, wave_pin_i};
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_sync
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
        end
        else
        begin
          sync1_reg[g] <= async_in[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  // registers
  logic [7:0] main_reg;
  logic [7:0] pol_reg;
  logic [7:0] sdc_reg;
  logic [7:0] sde_reg;
  logic [7:0] str_reg;
  logic [7:0] clk_reg;
  logic [7:0] sel_reg;
  logic [7:0] dbr_reg;
  logic [7:0] dbf_reg;
  logic [7:0] ist_reg;
  logic [7:0] imsk_reg;
  logic [3:0] str_act_reg;
  logic       wave_reg;
  logic       wave_prev_reg;
  wave_steer_pkg::out_state_e state_reg;
  wave_steer_pkg::out_state_e state_next;

  // bus holding state
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [5:0]  aw_addr_reg;
  logic [7:0]  w_data_reg;
  logic        w_lane0_reg;

  wire        aw_fire = s_axi_awvalid && s_axi_awready;
  wire        w_fire  = s_axi_wvalid && s_axi_wready;
  wire        ar_fire = s_axi_arvalid && s_axi_arready;
  wire        wr_do   = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire [3:0]  wr_idx  = reg_index(aw_addr_reg);
  wire [3:0]  rd_idx  = reg_index(s_axi_araddr);
  wire        wr_en   = wr_do && w_lane0_reg && (wr_idx != 4'hf);
  wire [7:0]  wd      = w_data_reg;
  wire [3:0]  idx_main = 4'(wave_steer_pkg::OFS_MAIN >> 2);
  wire [3:0]  idx_pol  = 4'(wave_steer_pkg::OFS_POL >> 2);
  wire [3:0]  idx_sdc  = 4'(wave_steer_pkg::OFS_SDC >> 2);
  wire [3:0]  idx_sde  = 4'(wave_steer_pkg::OFS_SDE >> 2);
  wire [3:0]  idx_str  = 4'(wave_steer_pkg::OFS_STR >> 2);
  wire [3:0]  idx_clk  = 4'(wave_steer_pkg::OFS_CLK >> 2);
  wire [3:0]  idx_sel  = 4'(wave_steer_pkg::OFS_SEL >> 2);
  wire [3:0]  idx_dbr  = 4'(wave_steer_pkg::OFS_DBR >> 2);
  wire [3:0]  idx_dbf  = 4'(wave_steer_pkg::OFS_DBF >> 2);
  wire [3:0]  idx_ist  = 4'(wave_steer_pkg::OFS_IST >> 2);
  wire [3:0]  idx_imsk = 4'(wave_steer_pkg::OFS_IMSK >> 2);

  // counting clock: fast oscillator edges become enable ticks
  wire osc_tick   = osc_sync_reg[1] && !osc_prev_reg;
  wire count_tick = clk_reg[0] ? osc_tick : 1'b1;                // R11

  // source selection; the top two codes land on tied-off zeros
  wire [15:0] src_pad  = {2'b00, sync2_reg[13:0]};               // R13
  wire        sel_wave = src_pad[sel_reg[3:0]];                  // R12
  wire        wave_rise = wave_reg && !wave_prev_reg;
  wire        wave_edge = wave_reg != wave_prev_reg;

  // shutdown sources
  wire [4:0] trip_vec = {sync2_reg[wave_steer_pkg::TRIP_LC2_SRC],
                         sync2_reg[wave_steer_pkg::TRIP_C2_SRC],
                         sync2_reg[wave_steer_pkg::TRIP_C1_SRC],
                         sync2_reg[15], sync2_reg[14]};
  wire       trip_any = |(trip_vec & sde_reg[4:0]);          // R1 R2 R3 R4 R5
  wire       sd_flag  = sdc_reg[wave_steer_pkg::SD_BIT];
  wire       sdc_wr   = wr_en && (wr_idx == idx_sdc);
  // a trip wins over a software clear in the same cycle
  wire       sd_next  = trip_any ? 1'b1 :                            // R17
                        sdc_wr ? wd[wave_steer_pkg::SD_BIT] :
                        (sd_flag && sdc_reg[wave_steer_pkg::REN_BIT])
                          ? 1'b0 : sd_flag;                          // R16

  wire [2:0] mode      = main_reg[2:0];
  wire       enabled   = main_reg[wave_steer_pkg::EN_BIT];
  wire       steer_md  = mode[2:1] == 2'b00;                         // R9
  wire       sync_md   = mode == wave_steer_pkg::MODE_SYNC;          // R14
  wire       plain_md  = mode == wave_steer_pkg::MODE_STEER;         // R14
  wire [1:0] lsac      = sdc_reg[wave_steer_pkg::LSAC_LSB +: 2];
  wire [1:0] lsbd      = sdc_reg[wave_steer_pkg::LSBD_LSB +: 2];

  // output levels for A..D
  logic [3:0] out_next;
  logic [3:0] oe_n_next;
  generate
    for (g = 0; g < 4; g++)
    begin : g_out
      wire [1:0] ls       = (g % 2 == 0) ? lsac : lsbd;
      wire       data_pol = wave_reg ^ pol_reg[g];                   // R15
      wire       ovr      = str_reg[wave_steer_pkg::OVR_LSB + g];
      wire       run_lvl  = !enabled ? pol_reg[g] :
                            !steer_md ? data_pol :                   // R9
                            str_act_reg[g] ? data_pol : ovr;         // R6 R7
      assign out_next[g]  = (state_reg == wave_steer_pkg::OUT_SHUT) ?
                            ((ls == wave_steer_pkg::LS_INACTIVE) ? pol_reg[g]
                            : (ls == wave_steer_pkg::LS_HIGH)) : run_lvl;
      assign oe_n_next[g] = (state_reg == wave_steer_pkg::OUT_SHUT) &&
                            (ls == wave_steer_pkg::LS_TRI);          // R17
    end
  endgenerate

  // outputs held in shutdown until a rising edge after the flag clears
  always_comb
  begin
    case (state_reg)
      wave_steer_pkg::OUT_RUN:
        state_next = sd_flag ? wave_steer_pkg::OUT_SHUT
                             : wave_steer_pkg::OUT_RUN;              // R17
      wave_steer_pkg::OUT_SHUT:
        state_next = (!sd_flag && wave_rise) ? wave_steer_pkg::OUT_RUN
                                             : wave_steer_pkg::OUT_SHUT;
      default:
        state_next = wave_steer_pkg::OUT_SHUT;
    endcase
  end

  // interrupt events; set wins over write-one-to-clear
  wire [7:0] irq_evt = {6'h00,
                        state_reg == wave_steer_pkg::OUT_SHUT &&
                        state_next == wave_steer_pkg::OUT_RUN,
                        trip_any && !sd_flag};
  wire [7:0] ist_clr = (wr_en && wr_idx == idx_ist) ? wd : 8'h00;
  wire [7:0] ist_next = (irq_evt | (ist_reg & ~ist_clr))
                        & wave_steer_pkg::WM_IRQ;

  // load request may only be raised while already enabled
  wire       ld_set  = wr_en && (wr_idx == idx_main) &&
                       wd[wave_steer_pkg::LD_BIT] && enabled;

  // read values; unimplemented bits are masked to zero
  logic [7:0] rd_vals [0:15];
  assign rd_vals[0]  = main_reg;
  assign rd_vals[1]  = pol_reg | {2'b00, wave_reg, 5'h00};
  assign rd_vals[2]  = sdc_reg;
  assign rd_vals[3]  = sde_reg;
  assign rd_vals[4]  = str_reg;
  assign rd_vals[5]  = clk_reg;
  assign rd_vals[6]  = sel_reg;
  assign rd_vals[7]  = dbr_reg;
  assign rd_vals[8]  = dbf_reg;
  assign rd_vals[9]  = ist_reg;
  assign rd_vals[10] = imsk_reg;
  generate
    for (g = 11; g < 16; g++)
    begin : g_unmapped
      assign rd_vals[g] = 8'h00;
    end
  endgenerate

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      main_reg <= wave_steer_pkg::RST_ZERO;
      pol_reg  <= wave_steer_pkg::RST_ZERO;
      sdc_reg  <= wave_steer_pkg::RST_SDC;
      sde_reg  <= wave_steer_pkg::RST_ZERO;
      str_reg  <= wave_steer_pkg::RST_ZERO;
      clk_reg  <= wave_steer_pkg::RST_ZERO;
      sel_reg  <= wave_steer_pkg::RST_ZERO;
      dbr_reg  <= wave_steer_pkg::RST_ZERO;
      dbf_reg  <= wave_steer_pkg::RST_ZERO;
      imsk_reg <= wave_steer_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_en && wr_idx == idx_main)
        main_reg <= wd & wave_steer_pkg::WM_MAIN & ~8'h40 | {1'b0, ld_set,
                    6'h00};                                          // R18
      else if (wave_edge)
        main_reg[wave_steer_pkg::LD_BIT] <= 1'b0;
      if (wr_en && wr_idx == idx_pol)
        pol_reg <= wd & wave_steer_pkg::WM_POL;                      // R18
      sdc_reg[wave_steer_pkg::SD_BIT] <= sd_next;
      if (sdc_wr)
        sdc_reg[6:0] <= wd[6:0] & wave_steer_pkg::WM_SDC[6:0];
      if (wr_en && wr_idx == idx_sde)
        sde_reg <= wd & wave_steer_pkg::WM_SDE;                      // R18
      if (wr_en && wr_idx == idx_str)
        str_reg <= wd & wave_steer_pkg::WM_STR;                      // R8
      if (wr_en && wr_idx == idx_clk)
        clk_reg <= wd & wave_steer_pkg::WM_CLK;
      if (wr_en && wr_idx == idx_sel)
        sel_reg <= wd & wave_steer_pkg::WM_SEL;
      if (wr_en && wr_idx == idx_dbr)
        dbr_reg <= wd & wave_steer_pkg::WM_DB;
      if (wr_en && wr_idx == idx_dbf)
        dbf_reg <= wd & wave_steer_pkg::WM_DB;
      if (wr_en && wr_idx == idx_imsk)
        imsk_reg <= wd & wave_steer_pkg::WM_IRQ;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      osc_sync_reg  <= 2'b00;
      osc_prev_reg  <= 1'b0;
      wave_reg      <= 1'b0;
      wave_prev_reg <= 1'b0;
      str_act_reg   <= 4'h0;
      state_reg     <= wave_steer_pkg::OUT_RUN;
      ist_reg       <= wave_steer_pkg::RST_ZERO;
      irq_o         <= 1'b0;
      out_o         <= 4'h0;
      out_oe_n_o    <= 4'h0;
    end
    else
    begin
      osc_sync_reg  <= {osc_sync_reg[0], fast_internal_oscillator_i};
      osc_prev_reg  <= osc_sync_reg[1];
      if (count_tick)
        wave_reg <= sel_wave;                                        // R11 R12
      wave_prev_reg <= wave_reg;
      // synchronous mode defers new enables to a clean waveform boundary
      if (plain_md || (sync_md && wave_rise))
        str_act_reg <= str_reg[3:0];                                 // R10
      state_reg     <= state_next;
      ist_reg       <= ist_next;
      irq_o         <= |(ist_next & imsk_reg);
      out_o         <= out_next;
      out_oe_n_o    <= oe_n_next;
    end
  end

  // axi4-lite slave: one write and one read outstanding
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_addr_reg   <= 6'h00;
      w_data_reg    <= 8'h00;
      w_lane0_reg   <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= wave_steer_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= wave_steer_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_full_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_fire)
      begin
        w_full_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata[7:0];
        w_lane0_reg  <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_do)
      begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx == 4'hf) ? wave_steer_pkg::RESP_SLVERR
                                         : wave_steer_pkg::RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_vals[rd_idx]};              // R18
        s_axi_rresp   <= (rd_idx == 4'hf) ? wave_steer_pkg::RESP_SLVERR
                                          : wave_steer_pkg::RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_TRIP_SETS_FLAG: assert property ( // R1 R2 R3 R4 R5 R17
    trip_any |=> sd_flag ##1 (state_reg == wave_steer_pkg::OUT_SHUT))
    else $error("enabled trip source did not enter shutdown");
  AST_MASKED_NO_TRIP: assert property ( // R1 R2 R3 R4 R5
    (!sd_flag && ((trip_vec & sde_reg[4:0]) == 5'h00) && !sdc_wr)
      |=> !sd_flag)
    else $error("shutdown flag set without an enabled source");
  AST_STEER_DATA: assert property ( // R6 R15
    (state_reg == wave_steer_pkg::OUT_RUN && enabled && steer_md &&
     str_act_reg[0]) |=> out_o[0] == ($past(wave_reg) ^ $past(pol_reg[0])))
    else $error("steered output A lost the waveform");
  AST_OVERRIDE: assert property ( // R7
    (state_reg == wave_steer_pkg::OUT_RUN && enabled && steer_md &&
     !str_act_reg[3]) |=> out_o[3] == $past(str_reg[7]))
    else $error("override level D not driven");
  AST_STR_LAYOUT: assert property ( // R8
    (wr_en && wr_idx == idx_str) |=> str_reg == $past(w_data_reg))
    else $error("steering register write lost");
  AST_OTHER_MODE: assert property ( // R9
    (state_reg == wave_steer_pkg::OUT_RUN && enabled && !steer_md)
      |=> out_o[1] == ($past(wave_reg) ^ $past(pol_reg[1])))
    else $error("steering applied outside steering modes");
  AST_SYNC_HOLD: assert property ( // R10 R14
    (sync_md && !wave_rise) |=> $stable(str_act_reg))
    else $error("sync steering changed off a rising edge");
  AST_OSC_GATE: assert property ( // R11
    (clk_reg[0] && !osc_tick) |=> $stable(wave_reg))
    else $error("waveform sampled without an oscillator tick");
  AST_PIN_SOURCE: assert property ( // R12
    (sel_reg[3:0] == 4'h0 && count_tick) |=> wave_reg == $past(sync2_reg[0]))
    else $error("select 0000 did not pass the input pin");
  AST_RESERVED_SEL: assert property ( // R13
    (sel_reg[3:1] == 3'h7 && count_tick) |=> !wave_reg)
    else $error("reserved select connected a source");
  AST_AUTO_RESTART: assert property ( // R16
    (sd_flag && sdc_reg[wave_steer_pkg::REN_BIT] && !trip_any && !sdc_wr)
      |=> !sd_flag)
    else $error("auto-restart did not clear shutdown flag");
  AST_SHUT_LEVEL: assert property ( // R17
    (state_reg == wave_steer_pkg::OUT_SHUT && lsac == wave_steer_pkg::LS_LOW)
      |=> !out_o[0] && !out_oe_n_o[0])
    else $error("shutdown level on A wrong");
  AST_READ_ZERO: assert property ( // R18
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("unimplemented read bits not zero");

  COV_SHUTDOWN: cover property (
    state_reg == wave_steer_pkg::OUT_SHUT ##[1:200]
    state_reg == wave_steer_pkg::OUT_RUN);
  COV_SYNC_LOAD: cover property (sync_md && wave_rise &&
    str_reg[3:0] != str_act_reg);
  COV_IRQ: cover property ($rose(irq_o));

endmodule
`default_nettype wire

//--- core/wave_steer_pkg.sv
// constants shared by the waveform steering and shutdown controller
package wave_steer_pkg;
  localparam int          ADDR_W       = 6;
  localparam int          NREG         = 11;
  localparam int          NSRC         = 14;
  // register byte offsets
  localparam logic [5:0]  OFS_MAIN     = 6'h00;
  localparam logic [5:0]  OFS_POL      = 6'h04;
  localparam logic [5:0]  OFS_SDC      = 6'h08;
  localparam logic [5:0]  OFS_SDE      = 6'h0c;
  localparam logic [5:0]  OFS_STR      = 6'h10;
  localparam logic [5:0]  OFS_CLK      = 6'h14;
  localparam logic [5:0]  OFS_SEL      = 6'h18;
  localparam logic [5:0]  OFS_DBR      = 6'h1c;
  localparam logic [5:0]  OFS_DBF      = 6'h20;
  localparam logic [5:0]  OFS_IST      = 6'h24;
  localparam logic [5:0]  OFS_IMSK     = 6'h28;
  // field positions
  localparam int          EN_BIT       = 7;
  localparam int          LD_BIT       = 6;
  localparam int          IN_BIT       = 5;
  localparam int          SD_BIT       = 7;
  localparam int          REN_BIT      = 6;
  localparam int          LSBD_LSB     = 4;
  localparam int          LSAC_LSB     = 2;
  localparam int          OVR_LSB      = 4;
  localparam int          TRIP_C1_SRC  = 8;
  localparam int          TRIP_C2_SRC  = 9;
  localparam int          TRIP_LC2_SRC = 11;
  localparam int          IRQ_TRIP     = 0;
  localparam int          IRQ_RESTART  = 1;
  // reset values and writable masks
  localparam logic [7:0]  RST_ZERO     = 8'h00;
  localparam logic [7:0]  RST_SDC      = 8'h14;
  localparam logic [7:0]  WM_MAIN      = 8'hc7;
  localparam logic [7:0]  WM_POL       = 8'h0f;
  localparam logic [7:0]  WM_SDC       = 8'hfc;
  localparam logic [7:0]  WM_SDE       = 8'h1f;
  localparam logic [7:0]  WM_STR       = 8'hff;
  localparam logic [7:0]  WM_CLK       = 8'h01;
  localparam logic [7:0]  WM_SEL       = 8'h0f;
  localparam logic [7:0]  WM_DB        = 8'h3f;
  localparam logic [7:0]  WM_IRQ       = 8'h03;
  // encodings
  localparam logic [2:0]  MODE_STEER   = 3'h0;
  localparam logic [2:0]  MODE_SYNC    = 3'h1;
  localparam logic [1:0]  LS_INACTIVE  = 2'h0;
  localparam logic [1:0]  LS_TRI       = 2'h1;
  localparam logic [1:0]  LS_LOW       = 2'h2;
  localparam logic [1:0]  LS_HIGH      = 2'h3;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic {OUT_RUN = 1'b0, OUT_SHUT = 1'b1} out_state_e;
endpackage

//--- tb/switch_driver_model.sv
// external switch drivers seen on output pins a to d
`timescale 1ns/1ps
`default_nettype none
module switch_driver_model (
  input  wire logic [3:0] drive_i,
  input  wire logic [3:0] oe_n_i,
  output logic      [3:0] pin_o
);
  // gate inputs carry pull-downs, so a released pin reads low
  assign pin_o = drive_i & ~oe_n_i;
endmodule
`default_nettype wire

//--- tb/tb_wave_steer_ctrl.sv
// self-checking bench for the waveform steering and shutdown controller
`timescale 1ns/1ps
`default_nettype none
module tb_wave_steer_ctrl;
  logic        clk_i, arst_n_i, awv, wv, bready, arv, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, osc, osc_en;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, r;
  logic [1:0]  bresp, rresp;
  logic [13:0] src;
  logic [4:0]  trip;
  logic [3:0]  out, oe_n, pin;
  logic [33:0] exq[$];
  int          err_total, checked, cyc, seed, i, c;
  wave_steer_ctrl i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wave_pin_i(src[0]),
    .ccp1_i(src[1]), .ccp2_i(src[2]), .pwm3_i(src[3]), .pwm4_i(src[4]),
    .pwm5_i(src[5]), .pwm6_i(src[6]), .nco_i(src[7]),
    .comparator1_i(src[8] | trip[2]), .comparator2_i(src[9] | trip[3]),
    .logic_cell1_i(src[10]), .logic_cell2_output_i(src[11] | trip[4]),
    .logic_cell3_i(src[12]), .logic_cell4_i(src[13]),
    .trip_pin_i(trip[0]), .eight_bit_timer_post_i(trip[1]),
    .fast_internal_oscillator_i(osc), .out_o(out), .out_oe_n_o(oe_n),
    .irq_o(irq));
  switch_driver_model i_sw (.drive_i(out), .oe_n_i(oe_n), .pin_o(pin));
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    err_total += exq.size();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic [1:0] bs = 2'h0);
    @(posedge clk_i);
    exq.push_back({bs, 32'h0});
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  // expectation is queued first; the monitor pairs it with the answer
  task automatic rd(input logic [5:0] a, input logic [7:0] d,
                    input logic [1:0] rs = 2'h0);
    @(posedge clk_i);
    exq.push_back({rs, 24'h0, d});
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arready) arv <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  always @(posedge clk_i)
  begin
    if (rvalid && rready) chk({rresp, rdata}, exq.pop_front());
    if (bvalid && bready) chk({bresp, 32'h0}, exq.pop_front());
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_total++;
      summarize();
    end
  end
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // odd period keeps the oscillator out of phase with the system clock
  initial
  begin
    osc = 1'b0;
    forever #31.3 osc = osc ^ osc_en;
  end
  initial
  begin
    seed = 58;
    {arst_n_i, awv, wv, bready, arv, rready, osc_en} = '0;
    {awaddr, araddr, wdata, src, trip} = '0;
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(wave_steer_pkg::OFS_STR, 8'h00);
    rd(wave_steer_pkg::OFS_SDC, 8'h14);
    rd(6'h2c, 8'h00, wave_steer_pkg::RESP_SLVERR);
    wr(6'h30, 8'hff, wave_steer_pkg::RESP_SLVERR);
    wr(wave_steer_pkg::OFS_SDE, 8'hff);
    rd(wave_steer_pkg::OFS_SDE, 8'h1f);
    wr(wave_steer_pkg::OFS_CLK, 8'hff);
    rd(wave_steer_pkg::OFS_CLK, 8'h01);
    wr(wave_steer_pkg::OFS_CLK, 8'h00);
    wr(wave_steer_pkg::OFS_SDE, 8'h00);
    for (c = 0; c < 16; c++)
    begin
      r = $random(seed);
      wr(wave_steer_pkg::OFS_SEL, 8'(c));
      src <= r[13:0];
      w(8);
      rd(wave_steer_pkg::OFS_POL, {2'h0, c < 14 && r[c], 5'h0});
    end
    wr(wave_steer_pkg::OFS_SEL, 8'h00);
    wr(wave_steer_pkg::OFS_MAIN, 8'h80);
    repeat (12)
    begin
      r = $random(seed);
      wr(wave_steer_pkg::OFS_STR, r[7:0]);
      wr(wave_steer_pkg::OFS_POL, {4'h0, r[11:8]});
      src <= {13'h0, r[12]};
      w(8);
      chk(34'(pin), 34'((r[3:0] & (r[11:8] ^ {4{r[12]}})) |
          (~r[3:0] & r[7:4])));
    end
    wr(wave_steer_pkg::OFS_STR, 8'h00);
    wr(wave_steer_pkg::OFS_POL, 8'h00);
    src <= 14'h1;
    wr(wave_steer_pkg::OFS_MAIN, 8'h82);
    w(8);
    chk(34'(pin), 34'hf);
    wr(wave_steer_pkg::OFS_MAIN, 8'h81);
    wr(wave_steer_pkg::OFS_STR, 8'h0f);
    w(8);
    chk(34'(pin), 34'h0);
    src <= 14'h0;
    w(8);
    src <= 14'h1;
    w(8);
    chk(34'(pin), 34'hf);
    wr(wave_steer_pkg::OFS_MAIN, 8'h80);
    wr(wave_steer_pkg::OFS_CLK, 8'h01);
    src <= 14'h0;
    w(10);
    chk(34'(pin), 34'hf);
    osc_en <= 1'b1;
    w(10);
    chk(34'(pin), 34'h0);
    osc_en <= 1'b0;
    wr(wave_steer_pkg::OFS_CLK, 8'h00);
    wr(wave_steer_pkg::OFS_SDC, 8'h6c);
    wr(wave_steer_pkg::OFS_IMSK, 8'h01);
    for (i = 0; i < 5; i++)
    begin
      wr(wave_steer_pkg::OFS_SDE, 8'h1f & ~(8'h1 << i));
      trip <= 5'h1 << i;
      w(8);
      rd(wave_steer_pkg::OFS_SDC, 8'h6c);
      wr(wave_steer_pkg::OFS_SDE, 8'h1 << i);
      w(8);
      rd(wave_steer_pkg::OFS_SDC, 8'hec);
      chk(34'(pin), 34'h5);
      chk(34'(irq), 34'h1);
      wr(wave_steer_pkg::OFS_IMSK, 8'h00);
      w(2);
      chk(34'(irq), 34'h0);
      wr(wave_steer_pkg::OFS_IMSK, 8'h01);
      trip <= 5'h0;
      w(8);
      rd(wave_steer_pkg::OFS_SDC, 8'h6c);
      wr(wave_steer_pkg::OFS_IST, 8'h03);
      w(2);
      chk(34'(irq), 34'h0);
    end
    // outputs stay in shutdown until the waveform rises again
    wr(wave_steer_pkg::OFS_SDC, 8'h64);
    w(2);
    chk(34'(oe_n), 34'h5);
    src <= 14'h1;
    w(8);
    chk(34'(pin), 34'hf);
    chk(34'(oe_n), 34'h0);
    rd(wave_steer_pkg::OFS_IST, 8'h02);
    w(4);
    summarize();
  end
endmodule
`default_nettype wire
